// [rtl/adc_mode_timing_control.sv]
// mode and timing control: mode register, booster, conversion timer
`timescale 1ns/1ps
`default_nettype none
module adc_mode_timing_control (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output amtc_pkg::amtc_core_s core,
	output logic convDone
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		BOOST_OFF,
		BOOST_SETTLE,
		BOOST_READY
	} amtc_boost_e;

	typedef struct packed {
		amtc_pkg::amtc_mode_s mode;
		amtc_boost_e boost;
		logic [11:0] settleCnt;
		logic [amtc_pkg::CNT_W-1:0] convCnt;
		logic running;
		logic start;
		logic abort;
		logic done;
		logic illegal;
		amtc_pkg::amtc_core_s core;
	} amtc_state_s;

	amtc_state_s st_r, st_nxt;
	logic modeWr;
	logic [7:0] modeWrData;
	logic [amtc_pkg::CNT_W-1:0] lutCycles;
	logic lutIllegal;
	logic [7:0] statusVal;
	amtc_pkg::amtc_mode_s wrMode;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	amtc_avalon_slave i_amtc_avalon_slave (
		.mclk(mclk),
		.rst(rst),
		.address(avs_address),
		.read(avs_read),
		.write(avs_write),
		.writedata(avs_writedata),
		.modeVal(st_r.mode),
		.statusVal(statusVal),
		.readdata(avs_readdata),
		.waitrequest(avs_waitrequest),
		.modeWr(modeWr),
		.modeWrData(modeWrData)
	);

	amtc_time_lut i_amtc_time_lut (
		.fast5v(st_r.mode.fast5v),
		.fast3v(st_r.mode.fast3v),
		.ratio(st_r.mode.ratio),
		.cycles(lutCycles),
		.illegal(lutIllegal)
	);

	// status: running, booster state, illegal setting seen
	assign statusVal = {4'h0, st_r.illegal, st_r.boost == BOOST_READY,
		st_r.boost != BOOST_OFF, st_r.running};
	assign wrMode = modeWrData;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic fastMode;
		logic [11:0] settleTarget;
		fastMode = 1'b0;
		settleTarget = 12'h000;
		st_nxt = st_r;
		st_nxt.start = 1'b0;
		st_nxt.abort = 1'b0;
		st_nxt.done = 1'b0;
		fastMode = st_r.mode.fast5v | st_r.mode.fast3v;
		settleTarget = fastMode ? 12'(amtc_pkg::SETTLE_FAST_CYC)
			: 12'(amtc_pkg::SETTLE_NORM_CYC);

		// register write; same-value rewrite in fast mode restarts
		if (modeWr) begin
			st_nxt.mode = wrMode;
			if (st_r.running && fastMode && wrMode.convEn
				&& wrMode == st_r.mode) begin
				st_nxt.abort = 1'b1;
				st_nxt.running = 1'b0;
			end
		end

		// forbidden combinations are flagged, not corrected
		if (lutIllegal) begin
			st_nxt.illegal = 1'b1;
		end

		// booster: explicit enable or auto-on with conversion enable
		case (st_r.boost)
			BOOST_OFF: begin
				if (st_r.mode.boostEn | st_r.mode.convEn) begin
					st_nxt.boost = BOOST_SETTLE;
					st_nxt.settleCnt = 12'h000;
				end
			end
			BOOST_SETTLE: begin
				if (~st_r.mode.boostEn & ~st_r.mode.convEn) begin
					st_nxt.boost = BOOST_OFF;
				end else if (st_r.settleCnt >= settleTarget - 12'h001) begin
					st_nxt.boost = BOOST_READY;
				end else begin
					st_nxt.settleCnt = st_r.settleCnt + 12'h001;
				end
			end
			BOOST_READY: begin
				if (~st_r.mode.boostEn & ~st_r.mode.convEn) begin
					st_nxt.boost = BOOST_OFF;
				end
			end
			default: st_nxt.boost = BOOST_OFF;
		endcase

		// conversion timer
		if (~st_r.mode.convEn) begin
			st_nxt.running = 1'b0;
			st_nxt.convCnt = '0;
		end else if (~st_nxt.running || st_nxt.abort) begin
			// begin (or restart) a conversion from the beginning
			st_nxt.running = 1'b1;
			st_nxt.start = 1'b1;
			st_nxt.convCnt = lutCycles - 10'h001;
		end else if (st_r.convCnt == '0) begin
			// back to back: conversions repeat while enabled
			st_nxt.done = 1'b1;
			st_nxt.start = 1'b1;
			st_nxt.convCnt = lutCycles - 10'h001;
		end else begin
			st_nxt.convCnt = st_r.convCnt - 10'h001;
		end

		// core bundle registered so every output is a flip-flop
		st_nxt.core.convRun = st_nxt.running;
		st_nxt.core.convStart = st_nxt.start;
		st_nxt.core.convAbort = st_nxt.abort;
		st_nxt.core.scanMode = st_nxt.mode.scanMode;
		st_nxt.core.boosterOn = st_nxt.boost != BOOST_OFF;
		st_nxt.core.boosterReady = st_nxt.boost == BOOST_READY;
		st_nxt.core.fast = st_nxt.mode.fast5v | st_nxt.mode.fast3v;
		// fast flags select the table row above
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= '0;
			st_r.mode <= amtc_pkg::MODE_RESET;
			st_r.boost <= BOOST_OFF;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign core = st_r.core;
	assign convDone = st_r.done;
endmodule
`default_nettype wire

// [common/amtc_pkg.sv]
// package: register map, field layout and timing constants for mode control
package amtc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int SETTLE_FAST_US = 1;
	localparam int SETTLE_NORM_US = 14;
	localparam int SETTLE_FAST_CYC = SETTLE_FAST_US * CLK_MHZ;
	localparam int SETTLE_NORM_CYC = SETTLE_NORM_US * CLK_MHZ;
	localparam int CNT_W = 10;

	// ----------------------------------------------------------------
	// register map (word addresses on the avalon bus)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// field layout of converter_mode_control
	// ----------------------------------------------------------------
	localparam int BIT_CONV_EN = 7;
	localparam int BIT_SCAN = 6;
	localparam int BIT_RATIO_HI = 5;
	localparam int BIT_RATIO_LO = 3;
	localparam int BIT_FAST5 = 2;
	localparam int BIT_FAST3 = 1;
	localparam int BIT_BOOST_EN = 0;

	typedef struct packed {
		logic convEn;
		logic scanMode;
		logic [2:0] ratio;
		logic fast5v;
		logic fast3v;
		logic boostEn;
	} amtc_mode_s;

	// core-facing control bundle
	typedef struct packed {
		logic convRun;
		logic convStart;
		logic convAbort;
		logic scanMode;
		logic boosterOn;
		logic boosterReady;
		logic fast;
	} amtc_core_s;

endpackage

// [rtl/amtc_time_lut.sv]
// lookup of conversion length in main-clock cycles from mode and ratio
`timescale 1ns/1ps
`default_nettype none
module amtc_time_lut (
	input wire logic fast5v,
	input wire logic fast3v,
	input wire logic [2:0] ratio,
	output logic [amtc_pkg::CNT_W-1:0] cycles,
	output logic illegal
);
	always_comb begin
		cycles = 10'h120;
		illegal = 1'b0;
		case ({fast5v, fast3v})
			2'b00: begin
				case (ratio)
					3'h0: cycles = 10'h120;
					3'h1: cycles = 10'h0f0;
					3'h2: cycles = 10'h0c0;
					3'h4: cycles = 10'h090;
					3'h5: cycles = 10'h078;
					3'h6: cycles = 10'h060;
					default: illegal = 1'b1;
				endcase
			end
			2'b01: begin
				case (ratio)
					3'h0: cycles = 10'h060;
					3'h1: cycles = 10'h048;
					3'h2: cycles = 10'h030;
					3'h3: cycles = 10'h018;
					3'h4: cycles = 10'h0e0;
					3'h5: cycles = 10'h0a8;
					3'h6: cycles = 10'h070;
					default: cycles = 10'h038;
				endcase
			end
			2'b10: begin
				case (ratio)
					3'h0: cycles = 10'h048;
					3'h1: cycles = 10'h036;
					3'h2: cycles = 10'h024;
					3'h3: cycles = 10'h012;
					default: illegal = 1'b1;
				endcase
			end
			default: illegal = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// [rtl/amtc_avalon_slave.sv]
// avalon-mm slave front end: decodes one access, one-cycle waitrequest
`timescale 1ns/1ps
`default_nettype none
module amtc_avalon_slave (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [7:0] modeVal,
	input wire logic [7:0] statusVal,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic modeWr,
	output logic [7:0] modeWrData
);
	// waitrequest drops for one cycle per access, so each access is seen once
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} amtc_bus_s;
	amtc_bus_s st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = (read | write) & ~st_r.ack;
		if (read & ~st_r.ack) begin
			case (address)
				amtc_pkg::ADDR_MODE: st_nxt.rdata = {24'h000000, modeVal};
				amtc_pkg::ADDR_STATUS:
					st_nxt.rdata = {24'h000000, statusVal};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign readdata = st_r.rdata;
	assign waitrequest = ~st_r.ack;
	// the write lands on the very edge that samples waitrequest low
	assign modeWr = write & st_r.ack & (address == amtc_pkg::ADDR_MODE);
	assign modeWrData = writedata[7:0];
endmodule
`default_nettype wire

// [testbench/amtc_asserts.sv]
// checker: port-level properties of the mode and timing control block
`timescale 1ns/1ps
`default_nettype none
module amtc_asserts (
	input wire logic mclk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire amtc_pkg::amtc_core_s core,
	input wire logic convDone
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// shortest table entry is 18 cycles, so 8 quiet cycles is always safe
	sequence s_quiet;
		!convDone [*8];
	endsequence
	// settling takes at least 50 cycles, well beyond this window
	sequence s_settle;
		!core.boosterReady [*8];
	endsequence
	chk_reset_idle: assert property (disable iff (1'b0)
		rst |=> !core.convRun && !core.boosterOn) else $error("not idle");
	chk_done_running: assert property (
		convDone |-> $past(core.convRun))
		else $error("done while stopped");
	chk_run_booster: assert property (
		core.convRun |-> core.boosterOn)
		else $error("running without booster");
	chk_ready_booster: assert property (
		core.boosterReady |-> core.boosterOn)
		else $error("ready while booster off");
	chk_settle_wait: assert property (
		$rose(core.boosterOn) |-> s_settle)
		else $error("booster ready too soon");
	// abort and restart are registered together, in the same cycle
	chk_abort_restart: assert property (
		core.convAbort |-> core.convStart)
		else $error("abort without restart");
	chk_min_length: assert property (
		core.convStart |=> s_quiet)
		else $error("conversion too short");
	chk_ack_request: assert property (!avs_waitrequest |-> avs_read || avs_write)
		else $error("ack without request");
	chk_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack longer than one cycle");
endmodule
bind adc_mode_timing_control amtc_asserts i_amtc_asserts (.mclk(mclk),
	.rst(rst), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .core(core), .convDone(convDone));
`default_nettype wire

// [testbench/amtc_core_model.sv]
// far-side model: measures the spacing of conversions seen by the core
`timescale 1ns/1ps
`default_nettype none
module amtc_core_model (
	input wire logic mclk,
	input wire logic rst,
	input wire amtc_pkg::amtc_core_s core,
	input wire logic convDone,
	output logic lenValid,
	output logic [15:0] lenSeen
);
	logic [15:0] cnt;
	logic seen;
	// the first conversion after a start is skipped: its start is not a done
	// a first result may predate booster settling
	always_ff @(posedge mclk) begin
		lenValid <= convDone && seen;
		lenSeen <= cnt;
		cnt <= convDone ? 16'h0001 : cnt + 16'h0001;
		if (rst || !core.convRun || core.convAbort) seen <= 1'b0;
		else if (convDone) seen <= 1'b1;
	end
endmodule
`default_nettype wire

// [testbench/test_adc_mode_timing_control.sv]
// self-checking bench: register access, timing table, booster control
`timescale 1ns/1ps
`default_nettype none
module test_adc_mode_timing_control;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, convDone, lenValid;
	logic [15:0] lenSeen;
	amtc_pkg::amtc_core_s core;
	logic [63:0] qRd[$];
	int qLen[$];
	int err_count = 0, n_compared = 0, cyc = 0, nAbort = 0;
	int nrm[8] = '{288, 240, 192, 0, 144, 120, 96, 0};
	int f3[8] = '{96, 72, 48, 24, 224, 168, 112, 56};
	int f5[8] = '{72, 54, 36, 18, 0, 0, 0, 0};
	logic [7:0] bs[5] = '{8'h80, 8'h00, 8'h81, 8'h01, 8'h00};
	logic eo[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [31:0] lfsrV = 32'hc395;
	always #10 mclk = ~mclk;
	adc_mode_timing_control i_adc_mode_timing_control (.mclk(mclk),
		.rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core(core), .convDone(convDone));
	amtc_core_model i_amtc_core_model (.mclk(mclk), .rst(rst), .core(core),
		.convDone(convDone), .lenValid(lenValid), .lenSeen(lenSeen));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("mismatches %0d compares %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// entered just after a rising edge; holds the request until acknowledged
	// the main clock always runs while the bus is used
	task automatic acc(input logic wr, input logic [3:0] a,
		input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		// waitrequest is registered: read it settled, act on the next rise
		do @(negedge mclk); while (avs_waitrequest !== 1'b0);
		@(posedge mclk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		qRd.push_back({24'hffffff, m, 24'h0, e});
		acc(1'b0, a, 8'h00);
	endtask
	// outputs are looked at on the falling edge, half a cycle after launch
	always @(negedge mclk) begin
		logic [63:0] n;
		int e;
		cyc++;
		if (core.convAbort === 1'b1) nAbort++;
		if (avs_read && avs_waitrequest === 1'b0 && qRd.size() > 0) begin
			n = qRd.pop_front();
			check(avs_readdata & n[63:32], n[31:0]);
		end
		if (lenValid === 1'b1 && qLen.size() > 0) begin
			e = qLen.pop_front();
			check(32'(lenSeen), 32'(e));
		end
		if (cyc == 90000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		logic [7:0] v;
		int len, nBefore;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(4'h0, 8'hff, 8'h00);
		rd(4'h7, 8'hff, 8'h00);
		for (int i = 0; i < 6; i++) begin
			lfsrV = lfsr(lfsrV);
			// enables and fast bits clear so nothing runs; ratios stay legal
			v = lfsrV[7:0] & 8'h68;
			acc(1'b1, 4'h0, v);
			rd(4'h0, 8'hff, v);
			check(32'(core.scanMode), 32'(v[6]));
		end
		for (int m = 0; m < 3; m++)
			for (int r = 0; r < 8; r++) begin
				len = m == 0 ? nrm[r] : m == 1 ? f3[r] : f5[r];
				if (len == 0) continue;
				v = {2'b10, r[2:0], m == 2, m == 1, 1'b1};
				acc(1'b1, 4'h0, 8'h00);
				acc(1'b1, 4'h0, v);
				check(32'(core.fast), 32'(m != 0));
				qLen.push_back(len);
				while (qLen.size() > 0) @(posedge mclk);
			end
		acc(1'b1, 4'h0, 8'h00);
		acc(1'b1, 4'h0, 8'h83);
		do @(negedge mclk); while (convDone !== 1'b1);
		@(posedge mclk);
		nBefore = nAbort;
		acc(1'b1, 4'h0, 8'h83);
		@(posedge mclk);
		check(32'(nAbort - nBefore), 32'h1);
		for (int i = 0; i < 5; i++) begin
			acc(1'b1, 4'h0, bs[i]);
			@(posedge mclk);
			check(32'(core.boosterOn), 32'(eo[i]));
			check(32'(core.convRun), 32'(bs[i][7]));
			if (i == 3) begin
				repeat (710) @(posedge mclk);
				rd(4'h1, 8'h07, 8'h06);
				check(32'(core.boosterReady), 32'h1);
			end
		end
		// only legal settings so far: the sticky flag must still be clear
		rd(4'h1, 8'h08, 8'h00);
		acc(1'b1, 4'h0, 8'h06);
		rd(4'h1, 8'h08, 8'h08);
		wrap_up();
	end
endmodule
`default_nettype wire
